/* File: common/acmp_defs.svh */
// Constants shared by the comparator control block.
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH

`define ACMP_NUM_CH    8
`define ACMP_NUM_PAIR  4
`define ACMP_CNT_W     10
`define ACMP_CNT_RESET 10'h000

`endif

/* File: common/acmp_pkg.sv */
// Types for the comparator control block.
package acmp_pkg;

  typedef enum logic [1:0] {
    acmp_off_mode           = 2'h0,
    continuous_measure_mode = 2'h1,
    user_triggered_mode     = 2'h2,
    event_triggered_mode    = 2'h3
  } acmp_mode_t;

  typedef enum logic [2:0] {
    acmp_st_off   = 3'h1,
    acmp_st_warm  = 3'h2,
    acmp_st_ready = 3'h4
  } acmp_state_t;

endpackage

/* File: common/acmp_chan_if.sv */
// Signals between the sequencer and one comparator channel.
`include "acmp_defs.svh"

interface acmp_chan_if #(
  parameter int CNT_W = `ACMP_CNT_W
);
  acmp_pkg::acmp_mode_t mode;
  logic                 run;
  logic                 tick;
  logic [CNT_W-1:0]     warmup;
  logic                 sample;
  logic                 start;
  logic                 ready;
  logic                 cur;
  logic                 result;
  logic                 done;
  logic                 pending;
  logic                 analog_en;

  modport ctrl (output mode, run, tick, warmup, sample, start,
                input  ready, cur, result, done, pending, analog_en);
  modport chan (input  mode, run, tick, warmup, sample, start,
                output ready, cur, result, done, pending, analog_en);
endinterface

/* File: verilog/acmp_sync.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain.
module acmp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: verilog/acmp_chan.sv */
// One comparator channel: startup count, ready flag and result sampling.
`include "acmp_defs.svh"

module acmp_chan #(
  parameter int CNT_W = `ACMP_CNT_W
) (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  reset,
  // Sequencer side
  acmp_chan_if.chan  bus
);
  acmp_pkg::acmp_state_t state;
  logic [CNT_W-1:0]      warm_cnt;
  logic                  active;
  logic                  warm_done;
  logic                  do_cmp;

  assign active    = bus.run && (bus.mode != acmp_pkg::acmp_off_mode); // RULE3
  assign warm_done = ({1'b0, warm_cnt} + {{CNT_W{1'b0}}, 1'b1}) >= {1'b0, bus.warmup};
  // Continuous mode samples every tick, single-shot modes only while a start is pending.
  assign do_cmp    = (state == acmp_pkg::acmp_st_ready) && active && bus.tick &&
                     ((bus.mode == acmp_pkg::continuous_measure_mode) || bus.pending); // RULE9 RULE10

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= acmp_pkg::acmp_st_off;
    end else begin
      case (state)
        acmp_pkg::acmp_st_off: begin
          if (active) state <= acmp_pkg::acmp_st_warm; // RULE22
        end
        acmp_pkg::acmp_st_warm: begin
          if (!active) state <= acmp_pkg::acmp_st_off;
          else if (bus.tick && warm_done) state <= acmp_pkg::acmp_st_ready; // RULE6 RULE7
        end
        acmp_pkg::acmp_st_ready: begin
          if (!active) state <= acmp_pkg::acmp_st_off; // RULE22
        end
        default: state <= acmp_pkg::acmp_st_off;
      endcase
    end
  end

  // Without comparator clock edges the count simply holds, so a stopped clock resumes cleanly.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) warm_cnt <= '0;
    else if (state != acmp_pkg::acmp_st_warm) warm_cnt <= '0; // RULE22
    else if (bus.tick && !(&warm_cnt)) warm_cnt <= warm_cnt + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE17
  end

  // A new start in the completing cycle wins and launches one more comparison.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) bus.pending <= 1'b0;
    else if (!active) bus.pending <= 1'b0;
    else if (bus.start) bus.pending <= 1'b1;
    else if (do_cmp) bus.pending <= 1'b0; // RULE11 RULE13
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus.done   <= 1'b0;
      bus.cur    <= 1'b0;
      bus.result <= 1'b0;
    end else begin
      bus.done <= do_cmp;
      if (do_cmp) bus.cur <= bus.sample; // RULE9
      if (!active || state != acmp_pkg::acmp_st_ready) bus.result <= 1'b0; // RULE21
      else if (do_cmp) bus.result <= bus.sample;
    end
  end

  assign bus.ready     = (state == acmp_pkg::acmp_st_ready); // RULE7
  assign bus.analog_en = (state != acmp_pkg::acmp_st_off);
endmodule

/* File: verilog/acmp_ctrl.sv */
// Sequencer for an array of analog comparators with window pairing.
`include "acmp_defs.svh"

// Operation
// RULE1: Window pairs are fixed couples 0-1, 2-3, 4-5, 6-7, numbered 0 to 3.
// RULE2: Outside window use every channel works on its own, ignoring its partner.
// RULE3: Nothing runs until global enable is set; each channel also needs a mode.
// RULE4: Mode field: 0 off, 1 continuous, 2 user single shot, 3 event single shot.
// RULE5: Channels may be mixed, some used alone while others form window pairs.
// RULE6: After enabling, count the startup time in comparator clock edges before results.
// RULE7: Ready bit sets once startup time passed; reads zero during startup.
// RULE8: A window pair is ready only when both its channels are ready.
// RULE9: Continuous mode samples every comparator clock edge into the current compare bit.
// RULE10: Continuous mode reports every comparison until the mode returns to off.
// RULE11: A user start launches exactly one comparison after startup, then nothing more.
// RULE12: Hardware clears the user start bit once its comparison completed.
// RULE13: With event trigger enabled, an event sets event start and runs one comparison.
// RULE14: Hardware clears the event start bit once its comparison completed.
// RULE15: The system clock must run at least four times the comparator clock.
// RULE16: Software should disable the block before stopping its clock.
// RULE17: A stopped clock halts the block; it resumes where it stopped.
// RULE18: The block keeps running while the processor is halted for debug.
// RULE19: One interrupt request output covers every interrupt source.
// RULE20: An event starts all event-mode channels together; other modes ignore it.
// RULE21: A channel's comparison output reads zero while its ready bit is zero.
// RULE22: Leaving off restarts the startup count; returning to off clears ready.
module acmp_ctrl #(
  parameter int NCH   = `ACMP_NUM_CH,
  parameter int NPAIR = `ACMP_NUM_PAIR,
  parameter int CNT_W = `ACMP_CNT_W
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // Control
  input  wire logic              global_enable,
  input  wire logic              event_trigger_enable_bit,
  input  wire logic [CNT_W-1:0]  startup_time_field,
  input  wire logic [2*NCH-1:0]  channel_config_reg,
  input  wire logic              user_start_write,
  // Peripheral event in
  input  wire logic              peripheral_event_in,
  // Comparator array
  input  wire logic              comparator_sample_clock,
  input  wire logic [NCH-1:0]    comparator_raw,
  output logic      [NCH-1:0]    comparator_enable,
  // Status
  output logic                   user_single_start_bit,
  output logic                   event_single_start_bit,
  output logic      [NCH-1:0]    channel_ready_bit,
  output logic      [NCH-1:0]    current_compare_bit,
  output logic      [NCH-1:0]    comparison_output,
  output logic      [NPAIR-1:0]  window_ready,
  // Events and interrupt
  output logic      [NCH-1:0]    compare_event,
  output logic                   irq
);
  logic           clk_sync;
  logic           clk_prev;
  logic           tick;
  logic [NCH-1:0] cmp_sync;
  logic [NCH-1:0] user_ch;
  logic [NCH-1:0] event_ch;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] start_ch;
  logic           trig_evt;
  logic           user_single_start_bit_launched;
  logic           event_single_start_bit_launched;

  acmp_sync #(.WIDTH(1)) u_clk_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (comparator_sample_clock),
    .q       (clk_sync)
  );

  acmp_sync #(.WIDTH(NCH)) u_cmp_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (comparator_raw),
    .q       (cmp_sync)
  );

  // Rising edges are found by sampling, which is only reliable with the 4x clock ratio.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) clk_prev <= 1'b0;
    else clk_prev <= clk_sync;
  end

  // No debug halt input: comparator timing runs on regardless of the processor.
  assign tick = clk_sync && !clk_prev; // RULE15 RULE18

  assign trig_evt = peripheral_event_in && event_trigger_enable_bit && global_enable; // RULE13

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      acmp_chan_if #(.CNT_W(CNT_W)) ch_if ();
      acmp_pkg::acmp_mode_t mode_i;

      assign mode_i      = acmp_pkg::acmp_mode_t'(channel_config_reg[2*i +: 2]); // RULE4
      assign user_ch[i]  = (mode_i == acmp_pkg::user_triggered_mode);
      assign event_ch[i] = (mode_i == acmp_pkg::event_triggered_mode);
      // Only this channel's own mode and start feed it, so partners never interact.
      assign start_ch[i] = (user_ch[i] && user_start_write) || (event_ch[i] && trig_evt); // RULE2 RULE20

      assign ch_if.mode   = mode_i;
      assign ch_if.run    = global_enable; // RULE3
      assign ch_if.tick   = tick;
      assign ch_if.warmup = startup_time_field;
      assign ch_if.sample = cmp_sync[i];
      assign ch_if.start  = start_ch[i];

      acmp_chan #(.CNT_W(CNT_W)) u_chan (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bus     (ch_if.chan)
      );

      assign pend[i]                = ch_if.pending;
      assign channel_ready_bit[i]   = ch_if.ready;
      assign current_compare_bit[i] = ch_if.cur;
      assign comparison_output[i]   = ch_if.result;
      assign compare_event[i]       = ch_if.done;
      assign comparator_enable[i]   = ch_if.analog_en;
    end

    for (i = 0; i < NPAIR; i++) begin : g_pair
      // Pairs are formed per pair, so single and paired channels can coexist.
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) window_ready[i] <= 1'b0;
        else window_ready[i] <= channel_ready_bit[2*i] && channel_ready_bit[2*i+1]; // RULE1 RULE5 RULE8
      end
    end
  endgenerate

  // The start bits are held one cycle after setting so the channels can latch their pending flag.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      user_single_start_bit <= 1'b0;
      user_single_start_bit_launched       <= 1'b0;
    end else begin
      user_single_start_bit_launched <= user_start_write;
      if (user_start_write) user_single_start_bit <= 1'b1;
      else if (!user_single_start_bit_launched && !(|(pend & user_ch))) user_single_start_bit <= 1'b0; // RULE12
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      event_single_start_bit <= 1'b0;
      event_single_start_bit_launched        <= 1'b0;
    end else begin
      event_single_start_bit_launched <= trig_evt;
      if (trig_evt) event_single_start_bit <= 1'b1; // RULE13
      else if (!event_single_start_bit_launched && !(|(pend & event_ch))) event_single_start_bit <= 1'b0; // RULE14
    end
  end

  // Interrupt tracks the completion pulses of all channels on one line.
  always_comb begin
    irq = |compare_event; // RULE19
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  generate
    for (i = 0; i < NCH; i++) begin : g_chk
      logic [CNT_W:0] tick_seen;

      // Counts comparator edges since the channel left off, apart from the channel's own counter.
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) tick_seen <= '0;
        else if (!comparator_enable[i]) tick_seen <= '0;
        else if (tick && !(&tick_seen)) tick_seen <= tick_seen + {{CNT_W{1'b0}}, 1'b1};
      end

      property p_off_not_ready;
        (!global_enable || channel_config_reg[2*i +: 2] == 2'h0) |=> !channel_ready_bit[i];
      endproperty
      a_off_not_ready: assert property (p_off_not_ready) else $error("ready while off"); // RULE22

      property p_output_gated;
        !channel_ready_bit[i] |-> !comparison_output[i];
      endproperty
      a_output_gated: assert property (p_output_gated) else $error("output while not ready"); // RULE21

      property p_ready_on_edge;
        $rose(channel_ready_bit[i]) |-> $past(tick) && $past(comparator_enable[i]);
      endproperty
      a_ready_on_edge: assert property (p_ready_on_edge) else $error("ready rose off a clock edge"); // RULE6

      property p_event_on_edge;
        compare_event[i] |-> $past(tick) && $past(channel_ready_bit[i]);
      endproperty
      a_event_on_edge: assert property (p_event_on_edge) else $error("comparison without edge"); // RULE9

      property p_cont_every_edge;
        tick && channel_ready_bit[i] && global_enable &&
        channel_config_reg[2*i +: 2] == 2'h1 |=> compare_event[i];
      endproperty
      a_cont_every_edge: assert property (p_cont_every_edge) else $error("continuous edge missed"); // RULE10

      property p_single_once;
        compare_event[i] && channel_config_reg[2*i +: 2] == 2'h2 && !$past(start_ch[i])
          |-> !g_ch[i].ch_if.pending;
      endproperty
      a_single_once: assert property (p_single_once) else $error("single shot stays pending"); // RULE11

      property p_user_ignores_event;
        user_ch[i] && !user_start_write |-> !start_ch[i];
      endproperty
      a_user_ignores_event: assert property (p_user_ignores_event) else $error("event hit user channel"); // RULE20

      property p_startup_length;
        $rose(channel_ready_bit[i]) |-> tick_seen >= {1'b0, startup_time_field};
      endproperty
      a_startup_length: assert property (p_startup_length) else $error("ready before startup time"); // RULE6

      property p_hold_no_tick;
        !tick && !channel_ready_bit[i] |=> !channel_ready_bit[i];
      endproperty
      a_hold_no_tick: assert property (p_hold_no_tick) else $error("ready rose without edge"); // RULE17

      property p_cur_sampled;
        compare_event[i] |-> current_compare_bit[i] == $past(cmp_sync[i]);
      endproperty
      a_cur_sampled: assert property (p_cur_sampled) else $error("current bit not from sample"); // RULE9

      property p_output_matches;
        compare_event[i] |-> comparison_output[i] == current_compare_bit[i];
      endproperty
      a_output_matches: assert property (p_output_matches) else $error("output differs from result"); // RULE21

      property p_off_drops_enable;
        !global_enable |=> !comparator_enable[i];
      endproperty
      a_off_drops_enable: assert property (p_off_drops_enable) else $error("channel on while disabled"); // RULE3

      property p_enable_restarts;
        $rose(comparator_enable[i]) |-> !channel_ready_bit[i];
      endproperty
      a_enable_restarts: assert property (p_enable_restarts) else $error("ready kept over restart"); // RULE22

      property p_event_starts_all;
        trig_evt && event_ch[i] |-> start_ch[i];
      endproperty
      a_event_starts_all: assert property (p_event_starts_all) else $error("event channel not started"); // RULE20

      property p_cont_no_start;
        channel_config_reg[2*i +: 2] == 2'h1 |-> !start_ch[i];
      endproperty
      a_cont_no_start: assert property (p_cont_no_start) else $error("continuous channel started"); // RULE20
    end

    for (i = 0; i < NPAIR; i++) begin : g_wchk
      property p_window_both;
        window_ready[i] |-> $past(channel_ready_bit[2*i]) && $past(channel_ready_bit[2*i+1]);
      endproperty
      a_window_both: assert property (p_window_both) else $error("window ready with one side idle"); // RULE8

      property p_window_drop;
        !(channel_ready_bit[2*i] && channel_ready_bit[2*i+1]) |=> !window_ready[i];
      endproperty
      a_window_drop: assert property (p_window_drop) else $error("window ready kept"); // RULE8
    end
  endgenerate

  property p_event_sets_start;
    peripheral_event_in && event_trigger_enable_bit && global_enable |=> event_single_start_bit [*2];
  endproperty
  a_event_sets_start: assert property (p_event_sets_start) else $error("event start not held"); // RULE13

  property p_event_disabled;
    !trig_evt && !event_single_start_bit |=> !event_single_start_bit;
  endproperty
  a_event_disabled: assert property (p_event_disabled) else $error("event start set unasked"); // RULE13

  property p_user_sets_start;
    user_start_write |=> user_single_start_bit ##1 user_single_start_bit;
  endproperty
  a_user_sets_start: assert property (p_user_sets_start) else $error("user start not held"); // RULE11

  property p_user_clears;
    user_single_start_bit && !user_single_start_bit_launched && !user_start_write && !(|(pend & user_ch))
      |=> !user_single_start_bit;
  endproperty
  a_user_clears: assert property (p_user_clears) else $error("user start not cleared"); // RULE12

  property p_event_clears;
    event_single_start_bit && !event_single_start_bit_launched && !trig_evt && !(|(pend & event_ch))
      |=> !event_single_start_bit;
  endproperty
  a_event_clears: assert property (p_event_clears) else $error("event start not cleared"); // RULE14

  property p_irq_tracks;
    irq == (|compare_event);
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("irq out of step"); // RULE19

  c_ready: cover property ($rose(channel_ready_bit[0]));
  c_window: cover property ($rose(window_ready[0]));
  c_user_done: cover property ($fell(user_single_start_bit));
  c_event_done: cover property ($fell(event_single_start_bit));
  c_continuous: cover property (compare_event[1] && channel_config_reg[3:2] == 2'h1);
endmodule

/* File: testbench/acmp_array_model.sv */
// Behavioural comparator array that also makes the comparator sample clock.
module acmp_array_model (
  // Comparator control
  input  wire logic [7:0] comparator_enable,
  input  wire logic [7:0] raw_val,
  // Comparator side
  output logic            comparator_sample_clock,
  output logic      [7:0] comparator_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  logic junk = 1'b0;

  // Ten system clocks per comparator clock keeps well above the 4x minimum.
  initial begin
    comparator_sample_clock = 1'b0;
    #13;
    forever #250 comparator_sample_clock = ~comparator_sample_clock;
  end

  // A disabled comparator gives no valid level, so its output wanders.
  always #37 junk = ~junk;

  assign comparator_raw = (raw_val & comparator_enable) | ({8{junk}} & ~comparator_enable);
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the comparator sequencer with random configurations.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        global_enable = 1'b0;
  logic        event_trigger_enable_bit = 1'b0;
  logic [9:0]  startup_time_field = 10'h000;
  logic [15:0] channel_config_reg = 16'h0000;
  logic        user_start_write = 1'b0;
  logic        peripheral_event_in = 1'b0;
  logic        comparator_sample_clock;
  logic [7:0]  comparator_raw;
  logic [7:0]  raw_val = 8'h00;
  logic [7:0]  comparator_enable;
  logic        user_single_start_bit;
  logic        event_single_start_bit;
  logic [7:0]  channel_ready_bit;
  logic [7:0]  current_compare_bit;
  logic [7:0]  comparison_output;
  logic [3:0]  window_ready;
  logic [7:0]  compare_event;
  logic        irq;
  logic [15:0] lfsr = 16'h1DEB;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cnt[8];
  int          first[8];

  always #25 sys_clk = ~sys_clk;

  acmp_ctrl DUT (
    .sys_clk                  (sys_clk),
    .reset                    (reset),
    .global_enable            (global_enable),
    .event_trigger_enable_bit (event_trigger_enable_bit),
    .startup_time_field       (startup_time_field),
    .channel_config_reg       (channel_config_reg),
    .user_start_write         (user_start_write),
    .peripheral_event_in      (peripheral_event_in),
    .comparator_sample_clock  (comparator_sample_clock),
    .comparator_raw           (comparator_raw),
    .comparator_enable        (comparator_enable),
    .user_single_start_bit    (user_single_start_bit),
    .event_single_start_bit   (event_single_start_bit),
    .channel_ready_bit        (channel_ready_bit),
    .current_compare_bit      (current_compare_bit),
    .comparison_output        (comparison_output),
    .window_ready             (window_ready),
    .compare_event            (compare_event),
    .irq                      (irq)
  );

  acmp_array_model array (
    .comparator_enable       (comparator_enable),
    .raw_val                 (raw_val),
    .comparator_sample_clock (comparator_sample_clock),
    .comparator_raw          (comparator_raw)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Ten comparator clocks fall inside one measuring window.
  function automatic int exp_cnt(input logic [1:0] m, input logic ev, input logic ge);
    if (!ge) return 0;
    case (acmp_pkg::acmp_mode_t'(m))
      acmp_pkg::continuous_measure_mode: return 10;
      acmp_pkg::user_triggered_mode:     return 1;
      acmp_pkg::event_triggered_mode:    return int'(ev);
      default:                           return 0;
    endcase
  endfunction

  function automatic logic [3:0] exp_win(input logic [7:0] m);
    logic [3:0] w;
    for (int p = 0; p < 4; p++) w[p] = m[2*p] & m[2*p+1];
    return w;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Settles just after a comparator clock rise has been taken by the design.
  task automatic sync_rise();
    @(posedge comparator_sample_clock);
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic run_window(input int cycles);
    for (int i = 0; i < 8; i++) begin
      cnt[i] = 0;
      first[i] = -1;
    end
    for (int t = 0; t < cycles; t++) begin
      @(negedge sys_clk);
      check(irq, |compare_event);
      for (int i = 0; i < 8; i++) if (compare_event[i] === 1'b1) begin
        cnt[i]++;
        if (first[i] < 0) first[i] = t;
      end
    end
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    logic [15:0] cfg;
    logic [7:0]  en;
    logic        ge;
    logic        ev;
    int          warm;
    int          ef;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    check({channel_ready_bit, compare_event}, 16'h0000);
    for (int r = 0; r < 8; r++) begin
      lfsr = lfsr_next(lfsr);
      raw_val = lfsr[7:0];
      lfsr = lfsr_next(lfsr);
      cfg = (r == 1) ? 16'hE4E4 : (r == 2) ? 16'hFFFF : lfsr;
      ge = (r != 0);
      ev = (r == 1) ? 1'b1 : (r == 2) ? 1'b0 : lfsr[3];
      warm = 2 + lfsr[5:4];
      for (int i = 0; i < 8; i++) en[i] = ge && (cfg[2*i+:2] != 2'h0);
      sync_rise();
      global_enable = ge;
      event_trigger_enable_bit = ev;
      startup_time_field = 10'(warm);
      channel_config_reg = cfg;
      repeat (warm - 1) sync_rise();
      check(channel_ready_bit, 8'h00);
      check(comparison_output, 8'h00);
      sync_rise();
      check(channel_ready_bit, en);
      check(comparator_enable, en);
      check(window_ready, exp_win(en));
      user_start_write = 1'b1;
      peripheral_event_in = 1'b1;
      @(negedge sys_clk);
      user_start_write = 1'b0;
      peripheral_event_in = 1'b0;
      if (ge) check(user_single_start_bit, 1'b1);
      check(event_single_start_bit, ev & ge);
      run_window(99);
      ef = -1;
      for (int i = 0; i < 8; i++) begin
        check(16'(cnt[i]), 16'(exp_cnt(cfg[2*i+:2], ev, ge)));
        if (cnt[i] > 0) check(current_compare_bit[i], raw_val[i]);
        if (cnt[i] > 0) check(comparison_output[i], raw_val[i]);
        if (cfg[2*i+:2] == 2'h3 && cnt[i] > 0 && ef >= 0) check(16'(first[i]), 16'(ef));
        if (cfg[2*i+:2] == 2'h3 && cnt[i] > 0 && ef < 0) ef = first[i];
      end
      check(user_single_start_bit, 1'b0);
      check(event_single_start_bit, 1'b0);
      // Odd rounds drop the global enable instead, so the block is idle before any clock could stop.
      if (r % 2 == 1) global_enable = 1'b0;
      else channel_config_reg = 16'h0000;
      repeat (2) @(negedge sys_clk);
      check(channel_ready_bit, 8'h00);
      check(comparator_enable, 8'h00);
      check(comparison_output, 8'h00);
      $display("round %0d done", r);
    end
    stop_test();
  end
endmodule
